// *** gopc_cfg.svh ***
// Purpose: register offsets, field positions and constants
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes: definitions only
`ifndef GOPC_CFG_SVH
`define GOPC_CFG_SVH
`define GOPC_OFS_STEER 8'h00
`define GOPC_OFS_FWPIX 8'h04
`define GOPC_OFS_WIN 8'h08
`define GOPC_STEER_WMASK 32'hFF7FF000
`define GOPC_FWPIX_WMASK 32'hC0F0F000
`define GOPC_WIN_WMASK 32'h0001FFFF
`define GOPC_SEL4_LSB 12
`define GOPC_SEL_W 3
`define GOPC_AGG_MSB 22
`define GOPC_AGG_LSB 21
`define GOPC_HJ_MSB 27
`define GOPC_HJ_LSB 24
`define GOPC_VJ_MSB 31
`define GOPC_VJ_LSB 28
`define GOPC_REV_MSB 11
`define GOPC_REV_LSB 0
`define GOPC_TRIM_MSB 15
`define GOPC_TRIM_LSB 12
`define GOPC_TYPE_MSB 19
`define GOPC_TYPE_LSB 16
`define GOPC_TRUNC_BIT 20
`define GOPC_CLIP_BIT 21
`define GOPC_BRST_BIT 23
`define GOPC_BANK_MSB 29
`define GOPC_BANK_LSB 24
`define GOPC_MUL_MSB 31
`define GOPC_MUL_LSB 30
`define GOPC_ACTIVE_CLOCKS_PER_LINE_MSB 16
`define GOPC_TRIM_MAX 4'h7
`define GOPC_CLIP_HI 240
`define GOPC_CLIP_LO 15
`define GOPC_LANE_KEEP 8
`define GOPC_AGG_LIM0 10'h000
`define GOPC_AGG_LIM1 10'h00F
`define GOPC_AGG_LIM2 10'h07F
`define GOPC_AGG_LIM3 10'h3FF
`define GOPC_RESP_OK 2'h0
`define GOPC_RESP_ERR 2'h2
`endif

// *** gopc_pkg.sv ***
// Purpose: shared types of the output steering and pixel control block
// Assumes: codes match the 3-bit selector fields
// Notes: pixel data width is fixed at 16 bits in gopc_pix_t, not set by a top parameter
package gopc_pkg;
	typedef enum logic [2:0] {
		GOPC_SRC_HOST = 3'h0,
		GOPC_SRC_T0 = 3'h1,
		GOPC_SRC_T1 = 3'h2,
		GOPC_SRC_T2 = 3'h3,
		GOPC_SRC_T3 = 3'h4,
		GOPC_SRC_CLK = 3'h5,
		GOPC_SRC_GEN = 3'h6,
		GOPC_SRC_RSV = 3'h7
	} gopc_src_t;
	typedef enum logic [1:0] {
		GOPC_MUL_X1 = 2'h0,
		GOPC_MUL_X2 = 2'h1,
		GOPC_MUL_R2 = 2'h2,
		GOPC_MUL_R3 = 2'h3
	} gopc_mul_t;
	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} gopc_pix_t;
endpackage

// *** gopc_top.sv ***
// Purpose: output pin steering, frame grouping, jump indices, line enable trim, pixel truncate/clip
// Assumes: every input is synchronous to clk; one write and one read at a time
// Notes: ce low freezes all state including the bus handshake
`include "gopc_cfg.svh"
module gopc_top
	import gopc_pkg::*;
#(
	parameter int AW = 8,
	parameter logic [11:0] FW_REV = 12'h001, // arbitrary value
	parameter logic [3:0] FW_KIND = 4'h1 // arbitrary value
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [2:0] hostOutBits,
	input wire logic [3:0] tableOut,
	input wire logic intClk,
	input wire logic sigGen,
	input wire logic frameDone,
	input wire logic lineEnableIn,
	input wire logic frameEnable,
	input wire gopc_pix_t pixIn,
	output logic [2:0] generalOutPin,
	output logic dmaFrameEnd,
	output logic lineEnableOut,
	output logic hJumpLoad,
	output logic [3:0] hJumpIdx,
	output logic vJumpLoad,
	output logic [3:0] vJumpIdx,
	output gopc_pix_t pixOut,
	output logic [17:0] lineClocks
);
	logic [31:0] steer_ff;
	logic [31:0] fwpix_ff;
	logic [31:0] win_ff;
	logic [AW-1:0] awAddr_ff;
	logic awHeld_ff;
	logic [31:0] wData_ff;
	logic [3:0] wStrb_ff;
	logic wHeld_ff;
	logic bValid_ff;
	logic [1:0] bResp_ff;
	logic rValid_ff;
	logic [31:0] rData_ff;
	logic [1:0] rResp_ff;
	logic [2:0] pin_ff;
	logic [9:0] aggCnt_ff;
	logic dmaEnd_ff;
	logic [5:0] bank_ff;
	logic [6:0] lenSh_ff;
	logic lenOut_ff;
	logic hLoad_ff;
	logic vLoad_ff;
	logic frameEnPrev_ff;
	gopc_pix_t pix_ff;
	logic [17:0] lineClk_ff;
	logic doWrite;
	logic [31:0] byteMask;
	logic [31:0] readWord;
	logic readHit;
	logic writeHit;
	logic [9:0] aggLim;
	logic [3:0] trimSel;
	logic lenTap;
	logic [15:0] pixNxt;
	logic [AW-1:0] awAddrEff;

	// bus readies: a held channel is refused until the response has gone
	assign s_axi_awready = ce && !awHeld_ff && !bValid_ff;
	assign s_axi_wready = ce && !wHeld_ff && !bValid_ff;
	assign s_axi_arready = ce && !rValid_ff;
	assign s_axi_bvalid = bValid_ff;
	assign s_axi_bresp = bResp_ff;
	assign s_axi_rvalid = rValid_ff;
	assign s_axi_rdata = rData_ff;
	assign s_axi_rresp = rResp_ff;
	assign doWrite = ce && awHeld_ff && wHeld_ff && !bValid_ff;

	// address and data may arrive in either order; each is latched alone
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			awHeld_ff <= 1'b0;
			wHeld_ff <= 1'b0;
			awAddr_ff <= '0;
			wData_ff <= 32'h0000_0000;
			wStrb_ff <= 4'h0;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeld_ff <= 1'b1;
				awAddr_ff <= s_axi_awaddr;
			end
			else if (doWrite)
				awHeld_ff <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeld_ff <= 1'b1;
				wData_ff <= s_axi_wdata;
				wStrb_ff <= s_axi_wstrb;
			end
			else if (doWrite)
				wHeld_ff <= 1'b0;
		end
	end

	// word-aligned decode; low address bits ignored
	assign awAddrEff = {awAddr_ff[AW-1:2], 2'h0};
	assign writeHit = (awAddrEff == AW'(`GOPC_OFS_STEER)) ||
		(awAddrEff == AW'(`GOPC_OFS_FWPIX)) || (awAddrEff == AW'(`GOPC_OFS_WIN));
	assign byteMask = {{8{wStrb_ff[3]}}, {8{wStrb_ff[2]}}, {8{wStrb_ff[1]}},
		{8{wStrb_ff[0]}}};

	// write response one cycle after both halves are held
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			bValid_ff <= 1'b0;
			bResp_ff <= `GOPC_RESP_OK;
		end
		else if (ce)
		begin
			if (doWrite)
			begin
				bValid_ff <= 1'b1;
				bResp_ff <= writeHit ? `GOPC_RESP_OK : `GOPC_RESP_ERR;
			end
			else if (s_axi_bready)
				bValid_ff <= 1'b0;
		end
	end

	// control registers; read-only bits, and reserved bits other than bit 22 of the firmware word, are never stored
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			steer_ff <= 32'h0000_0000;
			fwpix_ff <= 32'h0000_0000;
			win_ff <= 32'h0000_0000;
		end
		else if (doWrite)
		begin
			if (awAddrEff == AW'(`GOPC_OFS_STEER))
				steer_ff <= (steer_ff & ~(byteMask & `GOPC_STEER_WMASK)) |
					(wData_ff & byteMask & `GOPC_STEER_WMASK);
			if (awAddrEff == AW'(`GOPC_OFS_FWPIX))
				fwpix_ff <= (fwpix_ff & ~(byteMask & `GOPC_FWPIX_WMASK)) |
					(wData_ff & byteMask & `GOPC_FWPIX_WMASK);
			if (awAddrEff == AW'(`GOPC_OFS_WIN))
				win_ff <= (win_ff & ~(byteMask & `GOPC_WIN_WMASK)) |
					(wData_ff & byteMask & `GOPC_WIN_WMASK);
		end
	end

	// read word assembly: revision and kind come from parameters, bank from live state
	always_comb
	begin
		readWord = 32'h0000_0000;
		readHit = 1'b1;
		unique case ({s_axi_araddr[AW-1:2], 2'h0})
			AW'(`GOPC_OFS_STEER): readWord = steer_ff;
			AW'(`GOPC_OFS_FWPIX):
			begin
				readWord = fwpix_ff;
				readWord[`GOPC_REV_MSB:`GOPC_REV_LSB] = FW_REV;
				readWord[`GOPC_TYPE_MSB:`GOPC_TYPE_LSB] = FW_KIND;
				readWord[`GOPC_BANK_MSB:`GOPC_BANK_LSB] = bank_ff;
			end
			AW'(`GOPC_OFS_WIN): readWord = win_ff;
			default: readHit = 1'b0;
		endcase
	end

	// read data one cycle after the address is taken
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rValid_ff <= 1'b0;
			rData_ff <= 32'h0000_0000;
			rResp_ff <= `GOPC_RESP_OK;
		end
		else if (ce)
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				rValid_ff <= 1'b1;
				rData_ff <= readWord;
				rResp_ff <= readHit ? `GOPC_RESP_OK : `GOPC_RESP_ERR;
			end
			else if (s_axi_rready)
				rValid_ff <= 1'b0;
		end
	end

	// one source multiplexer per pin, registered so the pins never glitch
	function automatic logic pinSource(input gopc_src_t sel, input logic host);
		unique case (sel)
			GOPC_SRC_HOST: pinSource = host;
			GOPC_SRC_T0: pinSource = tableOut[0];
			GOPC_SRC_T1: pinSource = tableOut[1];
			GOPC_SRC_T2: pinSource = tableOut[2];
			GOPC_SRC_T3: pinSource = tableOut[3];
			GOPC_SRC_CLK: pinSource = intClk;
			GOPC_SRC_GEN: pinSource = sigGen;
			GOPC_SRC_RSV: pinSource = 1'b0;
		endcase
	endfunction

	for (genvar p = 0; p < 3; p++)
	begin : gPin
		always_ff @(posedge clk)
		begin
			if (rst)
				pin_ff[p] <= 1'b0;
			else if (ce)
				pin_ff[p] <= pinSource(gopc_src_t'(steer_ff[`GOPC_SEL4_LSB +
					p*`GOPC_SEL_W +: `GOPC_SEL_W]), hostOutBits[p]);
		end
	end
	assign generalOutPin = pin_ff;

	// frame grouping; a shrunk limit wraps at once rather than overrun
	always_comb
	begin
		unique case (steer_ff[`GOPC_AGG_MSB:`GOPC_AGG_LSB])
			2'h0: aggLim = `GOPC_AGG_LIM0;
			2'h1: aggLim = `GOPC_AGG_LIM1;
			2'h2: aggLim = `GOPC_AGG_LIM2;
			2'h3: aggLim = `GOPC_AGG_LIM3;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			aggCnt_ff <= 10'h000;
			dmaEnd_ff <= 1'b0;
		end
		else if (ce)
		begin
			dmaEnd_ff <= frameDone && (aggCnt_ff >= aggLim);
			if (frameDone)
				aggCnt_ff <= (aggCnt_ff >= aggLim) ? 10'h000 : aggCnt_ff + 10'h001;
		end
	end
	assign dmaFrameEnd = dmaEnd_ff;

	// starting bank steps per DMA frame; bank reset holds it at zero
	always_ff @(posedge clk)
	begin
		if (rst)
			bank_ff <= 6'h00;
		else if (ce)
		begin
			if (fwpix_ff[`GOPC_BRST_BIT])
				bank_ff <= 6'h00;
			else if (dmaEnd_ff)
				bank_ff <= bank_ff + 6'h01;
		end
	end

	// trim tap: values above seven are clamped to seven
	assign trimSel = (fwpix_ff[`GOPC_TRIM_MSB:`GOPC_TRIM_LSB] > `GOPC_TRIM_MAX) ?
		`GOPC_TRIM_MAX : fwpix_ff[`GOPC_TRIM_MSB:`GOPC_TRIM_LSB];
	assign lenTap = (trimSel == 4'h0) ? lineEnableIn : lenSh_ff[trimSel[2:0] - 3'h1];

	// line enable delay line; pixels pass the same single output stage
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			lenSh_ff <= 7'h00;
			lenOut_ff <= 1'b0;
		end
		else if (ce)
		begin
			lenSh_ff <= {lenSh_ff[5:0], lineEnableIn};
			lenOut_ff <= lenTap;
		end
	end
	assign lineEnableOut = lenOut_ff;

	// jump loads on the rising edge of the enables; only the line enable is trimmed
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			hLoad_ff <= 1'b0;
			vLoad_ff <= 1'b0;
			frameEnPrev_ff <= 1'b0;
		end
		else if (ce)
		begin
			hLoad_ff <= lenTap && !lenOut_ff;
			vLoad_ff <= frameEnable && !frameEnPrev_ff;
			frameEnPrev_ff <= frameEnable;
		end
	end
	assign hJumpLoad = hLoad_ff;
	assign vJumpLoad = vLoad_ff;
	// indices are entry numbers as written; no location translation here
	assign hJumpIdx = steer_ff[`GOPC_HJ_MSB:`GOPC_HJ_LSB];
	assign vJumpIdx = steer_ff[`GOPC_VJ_MSB:`GOPC_VJ_LSB];

	// truncate first, then clip, so clipping sees the truncated value
	always_comb
	begin
		pixNxt = pixIn.data;
		if (fwpix_ff[`GOPC_TRUNC_BIT])
			pixNxt = {8'h00, pixIn.data[`GOPC_LANE_KEEP-1:0]};
		if (fwpix_ff[`GOPC_CLIP_BIT])
		begin
			if (pixNxt > 16'(`GOPC_CLIP_HI))
				pixNxt = 16'(`GOPC_CLIP_HI);
			else if (pixNxt < 16'(`GOPC_CLIP_LO))
				pixNxt = 16'(`GOPC_CLIP_LO);
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			pix_ff <= '0;
		else if (ce)
		begin
			pix_ff.valid <= pixIn.valid;
			pix_ff.data <= pixNxt;
		end
	end
	assign pixOut = pix_ff;

	// effective line length; reserved multiplier codes act as code zero
	always_ff @(posedge clk)
	begin
		if (rst)
			lineClk_ff <= 18'h00000;
		else if (ce)
		begin
			if (gopc_mul_t'(fwpix_ff[`GOPC_MUL_MSB:`GOPC_MUL_LSB]) == GOPC_MUL_X2)
				lineClk_ff <= {win_ff[`GOPC_ACTIVE_CLOCKS_PER_LINE_MSB:0], 1'b0};
			else
				lineClk_ff <= {1'b0, win_ff[`GOPC_ACTIVE_CLOCKS_PER_LINE_MSB:0]};
		end
	end
	assign lineClocks = lineClk_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence sSel(int p, gopc_src_t c);
		ce && steer_ff[`GOPC_SEL4_LSB + p*`GOPC_SEL_W +: `GOPC_SEL_W] == c;
	endsequence

	a_pin_host: assert property (sSel(0, GOPC_SRC_HOST) |=>
		generalOutPin[0] == $past(hostOutBits[0]))
		else $error("pin 4 not following host bit");
	a_pin_clock: assert property (sSel(1, GOPC_SRC_CLK) |=>
		generalOutPin[1] == $past(intClk))
		else $error("pin 5 not following internal clock");
	a_pin_gen: assert property (sSel(2, GOPC_SRC_GEN) |=>
		generalOutPin[2] == $past(sigGen))
		else $error("pin 6 not following signal generator");
	a_pin_reserved: assert property (sSel(2, GOPC_SRC_RSV) |=> !generalOutPin[2])
		else $error("reserved selector did not drive low");
	a_group_single: assert property (ce && frameDone &&
		steer_ff[`GOPC_AGG_MSB:`GOPC_AGG_LSB] == 2'h0 |=> dmaFrameEnd)
		else $error("single-frame grouping missed a DMA end");
	a_hjump_load: assert property ($rose(lineEnableOut) |-> hJumpLoad)
		else $error("horizontal jump not loaded on line enable");
	a_vjump_load: assert property (ce && frameEnable && !frameEnPrev_ff |=>
		vJumpLoad && vJumpIdx == $past(steer_ff[`GOPC_VJ_MSB:`GOPC_VJ_LSB]))
		else $error("vertical jump not loaded on frame enable");
	a_trim_delay: assert property ((ce && trimSel == 4'h3)[*5] |->
		lineEnableOut == $past(lineEnableIn, 4))
		else $error("line enable trim delay wrong");
	a_clip_range: assert property (ce && fwpix_ff[`GOPC_CLIP_BIT] |=>
		pixOut.data <= 16'(`GOPC_CLIP_HI) && pixOut.data >= 16'(`GOPC_CLIP_LO))
		else $error("clipped pixel out of range");
	a_trunc_lanes: assert property (ce && fwpix_ff[`GOPC_TRUNC_BIT] &&
		!fwpix_ff[`GOPC_CLIP_BIT] |=> pixOut.data == {8'h00, $past(pixIn.data[7:0])})
		else $error("truncation kept upper lane bits");
	a_bank_reset: assert property (ce && fwpix_ff[`GOPC_BRST_BIT] |=> bank_ff == 6'h00)
		else $error("bank reset did not clear bank");
	a_line_double: assert property (ce &&
		fwpix_ff[`GOPC_MUL_MSB:`GOPC_MUL_LSB] == 2'h1 |=>
		lineClocks == {$past(win_ff[`GOPC_ACTIVE_CLOCKS_PER_LINE_MSB:0]), 1'b0})
		else $error("line length not doubled");
	a_read_fw: assert property (ce && s_axi_arvalid && s_axi_arready &&
		{s_axi_araddr[AW-1:2], 2'h0} == AW'(`GOPC_OFS_FWPIX) |=> s_axi_rvalid &&
		s_axi_rdata[`GOPC_REV_MSB:`GOPC_REV_LSB] == FW_REV &&
		s_axi_rdata[`GOPC_BANK_MSB:`GOPC_BANK_LSB] == $past(bank_ff))
		else $error("firmware word readback wrong");
endmodule // gopc_top

// *** gopc_top_tb.sv ***
// Purpose: self-checking bench for the output steering and pixel control block
// Assumes: offsets and masks of gopc_cfg.svh; bready and rready held high, ce high except during the two frozen checks before the last check
// Notes: pins, grouping, trim, jumps, pixel path and line length seen at the ports
`include "gopc_cfg.svh"
module gopc_top_tb
	import gopc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [11:0] REV = 12'h5A3; // arbitrary value
	localparam logic [3:0] KIND = 4'h9; // arbitrary value
	localparam logic [31:0] ID = {12'h000, KIND, 4'h0, REV};
	logic clk, rst, ce;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, tableOut, hJumpIdx, vJumpIdx;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [2:0] hostOutBits, generalOutPin, s4, s5, s6;
	logic intClk, sigGen, frameDone, lineEnableIn, frameEnable;
	logic dmaFrameEnd, lineEnableOut, hJumpLoad, vJumpLoad;
	logic [17:0] lineClocks;
	gopc_pix_t pixIn, pixOut;
	int nFail, samplesChecked, dmaCnt, vLoadCnt, k, startCnt;
	int trims [4] = '{0, 3, 7, 12};
	int aggN [4] = '{1, 16, 128, 1024};
	logic [15:0] pixData [6] = '{16'h1234, 16'h0005, 16'h0080, 16'h01F5, 16'h00F1, 16'h000F};

	gopc_top #(.AW(8), .FW_REV(REV), .FW_KIND(KIND)) gopc_top_i (
		.clk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .hostOutBits, .tableOut, .intClk, .sigGen, .frameDone,
		.lineEnableIn, .frameEnable, .pixIn, .generalOutPin, .dmaFrameEnd, .lineEnableOut,
		.hJumpLoad, .hJumpIdx, .vJumpLoad, .vJumpIdx, .pixOut, .lineClocks
	);

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// pulses counted at the falling edge, where registered outputs have settled
	always @(negedge clk)
	begin
		if (dmaFrameEnd === 1'b1) dmaCnt++;
		if (vJumpLoad === 1'b1) vLoadCnt++;
	end

	task automatic cmpVal(input string what, input logic [31:0] exp, input logic [31:0] got);
		samplesChecked++;
		if (got !== exp)
		begin
			nFail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// write with both channels offered together; readies looked at before the taking edge
	task automatic regWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic awT, wT, bT;
		logic [1:0] resp;
		int n;
		n = 0;
		bT = 1'b0;
		resp = 2'h3;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!bT && n < 64)
		begin
			@(negedge clk);
			awT = s_axi_awvalid && s_axi_awready;
			wT = s_axi_wvalid && s_axi_wready;
			bT = s_axi_bvalid === 1'b1;
			// a response is only taken while it is offered, so a hang cannot pass
			if (bT) resp = s_axi_bresp;
			@(posedge clk);
			if (awT) s_axi_awvalid <= 1'b0;
			if (wT) s_axi_wvalid <= 1'b0;
			n++;
		end
		cmpVal($sformatf("write response %h", a), {30'h0, er}, {30'h0, resp});
	endtask

	task automatic regCheck(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic arT, rT;
		logic [31:0] d;
		logic [1:0] resp;
		int n;
		n = 0;
		rT = 1'b0;
		resp = 2'h3;
		d = 32'h0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		while (!rT && n < 64)
		begin
			@(negedge clk);
			arT = s_axi_arvalid && s_axi_arready;
			rT = s_axi_rvalid === 1'b1;
			if (rT)
			begin
				d = s_axi_rdata;
				resp = s_axi_rresp;
			end
			@(posedge clk);
			if (arT) s_axi_arvalid <= 1'b0;
			n++;
		end
		cmpVal($sformatf("read response %h", a), {30'h0, er}, {30'h0, resp});
		cmpVal($sformatf("read data %h", a), exp, d);
	endtask

	function automatic logic srcBit(input logic [2:0] c, input int p);
		case (c)
			3'h0: return hostOutBits[p];
			3'h1, 3'h2, 3'h3, 3'h4: return tableOut[c - 3'h1];
			3'h5: return intClk;
			3'h6: return sigGen;
			default: return 1'b0;
		endcase
	endfunction

	// truncation first, then clipping, as the pixel path applies them
	function automatic logic [15:0] pixExp(input logic [15:0] d, input logic tr, input logic cl);
		logic [15:0] v;
		v = tr ? {8'h00, d[7:0]} : d;
		if (cl && v > 16'h00F0) v = 16'h00F0;
		if (cl && v < 16'h000F) v = 16'h000F;
		return v;
	endfunction

	function automatic logic [31:0] fwPix(input logic [1:0] mul, input logic brst,
		input logic cl, input logic tr, input logic [3:0] trim);
		return {mul, 6'h00, brst, 1'b0, cl, tr, 4'h0, trim, 12'h000};
	endfunction

	task automatic pulseFrames(input int n);
		for (int i = 0; i < n; i++)
		begin
			frameDone <= 1'b1;
			@(posedge clk);
			frameDone <= 1'b0;
			@(posedge clk);
		end
	endtask

	task automatic printVerdict();
		$display("checks %0d mismatches %0d", samplesChecked, nFail);
		if (nFail == 0 && samplesChecked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// the sequence takes under 15000 cycles, so a hang is cut well after that
	initial
	begin
		#(8 * 60000);
		nFail++;
		printVerdict();
	end

	initial
	begin
		{rst, ce, s_axi_bready, s_axi_rready} = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, frameDone, lineEnableIn, frameEnable} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, hostOutBits, tableOut, intClk, sigGen} = '0;
		s_axi_wstrb = 4'hF;
		pixIn = '0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// reset contents, unmapped place, write masks and read-only fields
		regCheck(`GOPC_OFS_STEER, 32'h0, `GOPC_RESP_OK);
		regCheck(`GOPC_OFS_FWPIX, ID, `GOPC_RESP_OK);
		regCheck(`GOPC_OFS_WIN, 32'h0, `GOPC_RESP_OK);
		regCheck(8'h0C, 32'h0, `GOPC_RESP_ERR);
		regWrite(8'h0C, 32'hFFFFFFFF, `GOPC_RESP_ERR);
		regWrite(`GOPC_OFS_STEER, 32'hFFFFFFFF, `GOPC_RESP_OK);
		regCheck(`GOPC_OFS_STEER, 32'hFF7FF000, `GOPC_RESP_OK);
		regWrite(`GOPC_OFS_FWPIX, 32'hFFFFFFFF, `GOPC_RESP_OK);
		regCheck(`GOPC_OFS_FWPIX, 32'hC0F0F000 | ID, `GOPC_RESP_OK);
		// every selector code on every pin, sources set both ways round
		for (int pass = 0; pass < 2; pass++)
		begin
			hostOutBits <= pass ? 3'h2 : 3'h5;
			tableOut <= pass ? 4'hA : 4'h5;
			intClk <= pass[0];
			sigGen <= !pass[0];
			for (int c = 0; c < 8; c++)
			begin
				s4 = c[2:0];
				s5 = s4 + 3'h1;
				s6 = s4 + 3'h2;
				regWrite(`GOPC_OFS_STEER, {8'h5A, 3'h0, s6, s5, s4, 12'h000}, `GOPC_RESP_OK);
				repeat (2) @(posedge clk);
				@(negedge clk);
				cmpVal("pins", {29'h0, srcBit(s6, 2), srcBit(s5, 1), srcBit(s4, 0)},
					{29'h0, generalOutPin});
				@(posedge clk);
			end
		end
		cmpVal("jump indices", 32'h5A, {24'h0, vJumpIdx, hJumpIdx});
		// frame grouping at each code; the bank advances per grouped frame
		regWrite(`GOPC_OFS_FWPIX, fwPix(2'h0, 1'b0, 1'b0, 1'b0, 4'h0), `GOPC_RESP_OK);
		for (int g = 0; g < 4; g++)
		begin
			regWrite(`GOPC_OFS_STEER, {8'h5A, 1'b0, g[1:0], 21'h0}, `GOPC_RESP_OK);
			startCnt = dmaCnt;
			pulseFrames(aggN[g] - 1);
			repeat (3) @(posedge clk);
			cmpVal("dma ends before last", 32'(startCnt), 32'(dmaCnt));
			pulseFrames(1);
			repeat (3) @(posedge clk);
			cmpVal("dma ends", 32'(startCnt + 1), 32'(dmaCnt));
		end
		regCheck(`GOPC_OFS_FWPIX, 32'h04000000 | ID, `GOPC_RESP_OK);
		regWrite(`GOPC_OFS_FWPIX, fwPix(2'h0, 1'b1, 1'b0, 1'b0, 4'h0), `GOPC_RESP_OK);
		regCheck(`GOPC_OFS_FWPIX, 32'h00800000 | ID, `GOPC_RESP_OK);
		regWrite(`GOPC_OFS_FWPIX, fwPix(2'h0, 1'b0, 1'b0, 1'b0, 4'h0), `GOPC_RESP_OK);
		regCheck(`GOPC_OFS_FWPIX, ID, `GOPC_RESP_OK);
		// line enable delay per trim value, with the horizontal load on its rise
		for (int t = 0; t < 4; t++)
		begin
			regWrite(`GOPC_OFS_FWPIX, fwPix(2'h0, 1'b0, 1'b0, 1'b0, trims[t][3:0]), `GOPC_RESP_OK);
			lineEnableIn <= 1'b1;
			k = 0;
			@(negedge clk);
			while (lineEnableOut !== 1'b1 && k < 20)
			begin
				@(posedge clk);
				@(negedge clk);
				k++;
			end
			cmpVal("line enable delay", 32'((trims[t] > 7) ? 8 : trims[t] + 1), 32'(k));
			cmpVal("horizontal load", 32'h1, {31'h0, hJumpLoad});
			@(posedge clk);
			lineEnableIn <= 1'b0;
			repeat (12) @(posedge clk);
		end
		frameEnable <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		cmpVal("vertical load", 32'h1, {31'h0, vJumpLoad});
		repeat (4) @(posedge clk);
		cmpVal("vertical loads", 32'h1, 32'(vLoadCnt));
		frameEnable <= 1'b0;
		// pixel path in all four truncate and clip settings
		for (int m = 0; m < 4; m++)
		begin
			regWrite(`GOPC_OFS_FWPIX, fwPix(2'h0, 1'b0, m[1], m[0], 4'h0), `GOPC_RESP_OK);
			for (int j = 0; j < 6; j++)
			begin
				pixIn <= {1'b1, pixData[j]};
				@(posedge clk);
				@(negedge clk);
				cmpVal("pixel", {15'h0, 1'b1, pixExp(pixData[j], m[0], m[1])},
					{15'h0, pixOut});
				@(posedge clk);
			end
			pixIn <= '0;
		end
		// line length at every multiplier code; reserved codes act as code zero
		regWrite(`GOPC_OFS_WIN, 32'hFFFFFFFF, `GOPC_RESP_OK);
		regCheck(`GOPC_OFS_WIN, 32'h0001FFFF, `GOPC_RESP_OK);
		regWrite(`GOPC_OFS_WIN, 32'h0001ABCD, `GOPC_RESP_OK);
		for (int u = 0; u < 4; u++)
		begin
			regWrite(`GOPC_OFS_FWPIX, fwPix(u[1:0], 1'b0, 1'b0, 1'b0, 4'h0), `GOPC_RESP_OK);
			repeat (3) @(posedge clk);
			@(negedge clk);
			cmpVal("line clocks", (u == 1) ? 32'h0003579A : 32'h0001ABCD,
				{14'h0, lineClocks});
			@(posedge clk);
		end
		// byte strobes: only byte one of the window word is replaced
		s_axi_wstrb <= 4'h2;
		regWrite(`GOPC_OFS_WIN, 32'h00005500, `GOPC_RESP_OK);
		s_axi_wstrb <= 4'hF;
		regCheck(`GOPC_OFS_WIN, 32'h000155CD, `GOPC_RESP_OK);
		// clock enable low freezes the pixel stage and refuses the bus
		ce <= 1'b0;
		pixIn <= {1'b1, 16'h0077};
		repeat (3) @(posedge clk);
		@(negedge clk);
		cmpVal("frozen pixel", 32'h0, {15'h0, pixOut});
		cmpVal("frozen read ready", 32'h0, {31'h0, s_axi_arready});
		@(posedge clk);
		ce <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		cmpVal("pixel after enable", 32'h00010077, {15'h0, pixOut});
		@(posedge clk);
		pixIn <= '0;
		printVerdict();
	end
endmodule // gopc_top_tb
